// ---- rtl/sere_defs.svh ----
// Constants of the serial nonvolatile memory command block.
// Included by the package users; holds definitions only.
`ifndef SERE_DEFS_SVH
`define SERE_DEFS_SVH

// Command opcodes
`define SERE_OP_READ 8'h03
`define SERE_OP_FAST_READ 8'h0B
`define SERE_OP_PROGRAM 8'h02
`define SERE_OP_PAGE_ERASE 8'h42
`define SERE_OP_STORE_UNLOCK 8'h06
`define SERE_OP_STATUS_FETCH 8'h05

// Array geometry
`define SERE_ADDR_W 15
`define SERE_PAGE_OFFS_W 6
`define SERE_PAGE_NUM_W 9
`define SERE_ERASED_BYTE 8'hFF

// Status byte fields
`define SERE_STAT_BUSY_BIT 0
`define SERE_STAT_WEL_BIT 1

// Reset values of the pin synchronisers: select high, clock low, data high
`define SERE_PIN_IDLE 3'h5

// Timing
`define SERE_CLK_PERIOD_NS 50
`define SERE_CYCLE_TIME_NS 1000000
`define SERE_BUSY_CYC \
  ((`SERE_CYCLE_TIME_NS + `SERE_CLK_PERIOD_NS - 1) / `SERE_CLK_PERIOD_NS)
`define SERE_FAST_READ_MAX_KHZ 10000

`endif

// ---- rtl/sere_pkg.sv ----
// Types shared by the serial nonvolatile memory command block.
// Assumes the constants header is compiled alongside.
package sere_pkg;

  // Frame phases, one-hot
  typedef enum logic [7:0] {
    ST_CMD    = 8'h01,
    ST_ADDR   = 8'h02,
    ST_DUMMY  = 8'h04,
    ST_RDATA  = 8'h08,
    ST_STAT   = 8'h10,
    ST_WDATA  = 8'h20,
    ST_HOLD   = 8'h40,
    ST_IGNORE = 8'h80
  } sereState_t;

  // One received program byte and its place in the page
  typedef struct packed {
    logic [5:0] offs;
    logic [7:0] data;
  } sereWrEntry_t;

  // Status byte as shifted out
  typedef struct packed {
    logic [5:0] rsvd;
    logic write_enable_latch;
    logic busy;
  } sereStatus_t;

endpackage : sere_pkg

// ---- rtl/sere_mem.sv ----
// Single-port byte memory with registered read data.
// Assumes one clock; no reset, contents undefined until written.
`timescale 1ns/1ns
module sere_mem #(
  parameter int AddrW = 15,
  parameter int DataW = 8
) (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic we,
  input wire logic [AddrW-1:0] addr,
  input wire logic [DataW-1:0] wdata,
  output logic [DataW-1:0] rdata
);

  logic [DataW-1:0] mem [0:(1<<AddrW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : sere_mem

// ---- rtl/sere_core.sv ----
// Command logic of a 32 KiB serial nonvolatile memory behind a 4-wire
// shift link: read, fast read, page program, page erase, status fetch.
// Assumes the link pins are asynchronous to clk and much slower than it.
//
// Overview of operation
// RULE_01 - Select low, opcode 03h, two address bytes, then data out MSB first.
// RULE_02 - Two address bytes always sent; only fifteen low bits decoded.
// RULE_03 - After read opcode and address, input line ignored until deselect.
// RULE_04 - Host deselects after eighth data bit to end a single-byte read.
// RULE_05 - Staying selected increments address and sends the next byte.
// RULE_06 - Continuous read wraps from the top address to zero.
// RULE_07 - Fast read 0Bh: address, eight ignored dummy bits, then data.
// RULE_08 - Fast read streams sequentially and wraps to zero as well.
// RULE_09 - Program 02h: opcode, two address bytes, one or more data bytes.
// RULE_10 - Program without write enable latch ignored until next select.
// RULE_11 - Deselect right after last data bit starts self-timed program.
// RULE_12 - During a self-timed cycle only status fetch is accepted.
// RULE_13 - Status bit 0 is busy: one while program or erase runs.
// RULE_14 - Program increments only six low address bits; page wraps.
// RULE_15 - Over 64 bytes: the last 64 received are written in page.
// RULE_16 - Fewer than 64 bytes: other bytes of the page stay unchanged.
// RULE_17 - Write enable latch cleared when a program cycle completes.
// RULE_18 - Write enable latch set only when select rises after 06h.
// RULE_19 - Page erase sets whole 64-byte page to ones; needs latch.
// RULE_20 - Deselect after erase address starts it; host polls busy.
// RULE_21 - Write enable 06h and status fetch 05h are single bytes.
// RULE_22 - Page erase opcode 42h precedes two page address bytes.
// RULE_23 - Latch unchanged if select rises off an eight-bit boundary.
// RULE_24 - Input sampled on clock rise, output changed on fall, MSB first.
`timescale 1ns/1ns
`include "sere_defs.svh"
module sere_core #(
  parameter int BusyCycles = `SERE_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic deviceSelectN,
  input wire logic shiftClock,
  input wire logic serialInLine,
  output logic serialOutLine_q,
  output logic serialOutEnN_q,
  // Device state
  output logic busyFlag_q,
  output logic writeEnableLatch_q
);
  import sere_pkg::*;

  function automatic sereState_t cmdNext(input logic [7:0] op,
                                         input logic busy,
                                         input logic write_enable_latch);
    sereState_t nxt;
    nxt = ST_IGNORE;
    if (op == `SERE_OP_STATUS_FETCH) begin
      nxt = ST_STAT;
    end else if (busy) begin
      nxt = ST_IGNORE; // RULE_12
    end else begin
      case (op)
        `SERE_OP_READ, `SERE_OP_FAST_READ: nxt = ST_ADDR;
        `SERE_OP_PROGRAM, `SERE_OP_PAGE_ERASE: begin
          nxt = write_enable_latch ? ST_ADDR : ST_IGNORE; // RULE_10
        end
        `SERE_OP_STORE_UNLOCK: nxt = ST_HOLD;
        default: nxt = ST_IGNORE;
      endcase
    end
    return nxt;
  endfunction : cmdNext

  // Pin synchronisers, {select, clock, data}
  logic [2:0] pinMeta_q;
  logic [2:0] pinSync_q;
  logic [2:0] pinPrev_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinMeta_q <= `SERE_PIN_IDLE;
      pinSync_q <= `SERE_PIN_IDLE;
      pinPrev_q <= `SERE_PIN_IDLE;
    end else begin
      pinMeta_q <= {deviceSelectN, shiftClock, serialInLine};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic csLow;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic serial_in_line;
  assign csLow = ~pinSync_q[2];
  assign csRise = pinSync_q[2] & ~pinPrev_q[2];
  assign sckRise = csLow & pinSync_q[1] & ~pinPrev_q[1]; // RULE_24
  assign sckFall = csLow & ~pinSync_q[1] & pinPrev_q[1]; // RULE_24
  assign serial_in_line = pinSync_q[0];

  // Bit receiver
  logic [2:0] bitCnt_q;
  logic [6:0] rxShift_q;
  logic [7:0] rxByte;
  logic byteDone;
  logic aligned;
  assign rxByte = {rxShift_q, serial_in_line};
  assign byteDone = sckRise & (bitCnt_q == 3'h7);
  // Counter still holds the frame's value in the csRise cycle
  assign aligned = (bitCnt_q == 3'h0); // RULE_23

  always_ff @(posedge clk) begin
    if (sys_rst || !csLow) begin
      bitCnt_q <= 3'h0;
      rxShift_q <= 7'h00;
    end else if (sckRise) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      rxShift_q <= {rxShift_q[5:0], serial_in_line};
    end
  end

  // Frame decoder
  sereState_t state_q;
  logic [7:0] cmd_q;
  logic addrByte_q;
  logic [`SERE_ADDR_W-1:0] addr_q;
  logic [5:0] wrOffs_q;
  logic dataSeen_q;
  logic startPend_q;

  // FIFO fill side
  logic fifoInReady;
  logic fifoPush;
  assign fifoPush = byteDone & (state_q == ST_WDATA) & fifoInReady;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_CMD;
      cmd_q <= 8'h00;
      addrByte_q <= 1'b0;
      addr_q <= 15'h0000;
      wrOffs_q <= 6'h00;
      dataSeen_q <= 1'b0;
    end else if (!csLow) begin
      state_q <= ST_CMD;
      addrByte_q <= 1'b0;
      dataSeen_q <= 1'b0;
    end else if (byteDone) begin
      case (state_q)
        ST_CMD: begin
          cmd_q <= rxByte; // RULE_21 RULE_22
          state_q <= cmdNext(rxByte, busyFlag_q | startPend_q,
                             writeEnableLatch_q);
        end
        ST_ADDR: begin
          addrByte_q <= 1'b1;
          if (!addrByte_q) begin
            addr_q[14:8] <= rxByte[6:0]; // RULE_02
          end else begin
            addr_q[7:0] <= rxByte; // RULE_01
            wrOffs_q <= rxByte[5:0];
            case (cmd_q)
              `SERE_OP_READ: state_q <= ST_RDATA; // RULE_01
              `SERE_OP_FAST_READ: state_q <= ST_DUMMY; // RULE_07
              `SERE_OP_PROGRAM: state_q <= ST_WDATA; // RULE_09
              default: state_q <= ST_HOLD; // RULE_20
            endcase
          end
        end
        ST_DUMMY: state_q <= ST_RDATA; // RULE_07
        ST_RDATA: begin
          // Input ignored here; address wraps past the top
          addr_q <= addr_q + 15'h0001; // RULE_03 RULE_05 RULE_06 RULE_08
        end
        ST_WDATA: begin
          wrOffs_q <= wrOffs_q + 6'h01; // RULE_14
          dataSeen_q <= 1'b1;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  logic progOk;
  logic eraseOk;
  logic wrenOk;
  logic clearValid;
  assign progOk = csRise & aligned & dataSeen_q &
                  (state_q == ST_WDATA); // RULE_11
  assign eraseOk = csRise & aligned & (state_q == ST_HOLD) &
                   (cmd_q == `SERE_OP_PAGE_ERASE); // RULE_20
  assign wrenOk = csRise & aligned & (state_q == ST_HOLD) &
                  (cmd_q == `SERE_OP_STORE_UNLOCK); // RULE_18
  assign clearValid = byteDone & (state_q == ST_ADDR) & addrByte_q &
                      (cmd_q == `SERE_OP_PROGRAM);

  // Two-entry buffer between receiver and page buffer
  sereWrEntry_t fifoMem_q [0:1];
  logic fifoWrPtr_q;
  logic fifoRdPtr_q;
  logic [1:0] fifoCount_q;
  logic fifoOutValid;
  logic fifoOutReady;
  logic fifoPop;
  logic commitRun_q;
  assign fifoInReady = (fifoCount_q != 2'h2);
  assign fifoOutValid = (fifoCount_q != 2'h0);
  // Page buffer port is taken by the commit walk
  assign fifoOutReady = ~commitRun_q;
  assign fifoPop = fifoOutValid & fifoOutReady;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifoWrPtr_q <= 1'b0;
      fifoRdPtr_q <= 1'b0;
      fifoCount_q <= 2'h0;
    end else begin
      if (fifoPush) begin
        fifoMem_q[fifoWrPtr_q] <= '{offs: wrOffs_q, data: rxByte};
        fifoWrPtr_q <= ~fifoWrPtr_q;
      end
      if (fifoPop) begin
        fifoRdPtr_q <= ~fifoRdPtr_q;
      end
      fifoCount_q <= fifoCount_q + {1'b0, fifoPush} - {1'b0, fifoPop};
    end
  end

  // Page buffer with per-byte valid marks
  logic [63:0] pageValid_q;
  logic [5:0] pbAddr;
  logic [7:0] pbRdata;
  logic [6:0] commitIdx_q;
  sereWrEntry_t fifoHead;
  assign fifoHead = fifoMem_q[fifoRdPtr_q];
  assign pbAddr = commitRun_q ? commitIdx_q[5:0] : fifoHead.offs;

  always_ff @(posedge clk) begin
    if (sys_rst || clearValid) begin
      pageValid_q <= 64'h0; // RULE_16
    end else if (fifoPop) begin
      pageValid_q[fifoHead.offs] <= 1'b1;
    end
  end

  // Later bytes overwrite earlier ones at the same offset
  sere_mem #(.AddrW(`SERE_PAGE_OFFS_W), .DataW(8)) pageBuf (
    .clk(clk),
    .we(fifoPop), // RULE_15
    .addr(pbAddr),
    .wdata(fifoHead.data),
    .rdata(pbRdata)
  );

  // Self-timed cycle: walk the page while the busy time counts down
  logic eraseMode_q;
  logic [`SERE_PAGE_NUM_W-1:0] commitPage_q;
  logic [19:0] busyCnt_q;
  logic wrStage_q;
  logic [5:0] stageOffs_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startPend_q <= 1'b0;
      commitRun_q <= 1'b0;
      commitIdx_q <= 7'h00;
      eraseMode_q <= 1'b0;
      commitPage_q <= 9'h000;
      busyCnt_q <= 20'h00000;
      wrStage_q <= 1'b0;
      stageOffs_q <= 6'h00;
    end else begin
      wrStage_q <= commitRun_q;
      stageOffs_q <= commitIdx_q[5:0];
      if (progOk || eraseOk) begin
        startPend_q <= 1'b1;
        eraseMode_q <= eraseOk;
        commitPage_q <= addr_q[14:6]; // RULE_14 RULE_19
      end else if (startPend_q && !fifoOutValid) begin
        // Wait for the buffer to drain before walking the page
        startPend_q <= 1'b0;
        commitRun_q <= 1'b1;
        commitIdx_q <= 7'h00;
        busyCnt_q <= 20'(BusyCycles);
      end else begin
        if (commitRun_q) begin
          commitIdx_q <= commitIdx_q + 7'h01;
          if (commitIdx_q == 7'h3F) begin
            commitRun_q <= 1'b0;
          end
        end
        if (busyCnt_q != 20'h00000) begin
          busyCnt_q <= busyCnt_q - 20'h00001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busyFlag_q <= 1'b0;
    end else if (progOk || eraseOk) begin
      busyFlag_q <= 1'b1; // RULE_13
    end else if (busyCnt_q == 20'h00001) begin
      busyFlag_q <= 1'b0; // RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      writeEnableLatch_q <= 1'b0;
    end else if (busyCnt_q == 20'h00001) begin
      writeEnableLatch_q <= 1'b0; // RULE_17
    end else if (wrenOk) begin
      writeEnableLatch_q <= 1'b1; // RULE_18
    end
  end

  // Main array, shared by reads and the commit walk
  logic arrWe;
  logic [`SERE_ADDR_W-1:0] arrAddr;
  logic [7:0] arrWdata;
  logic [7:0] arrRdata;
  assign arrWe = wrStage_q & (eraseMode_q | pageValid_q[stageOffs_q]);
  assign arrAddr = wrStage_q ? {commitPage_q, stageOffs_q} : addr_q;
  assign arrWdata = eraseMode_q ? `SERE_ERASED_BYTE : pbRdata; // RULE_19

  sere_mem #(.AddrW(`SERE_ADDR_W), .DataW(8)) array (
    .clk(clk),
    .we(arrWe), // RULE_16
    .addr(arrAddr),
    .wdata(arrWdata),
    .rdata(arrRdata)
  );

  // Output shifter, changes on falling shift clock edges
  sereStatus_t statusByte;
  logic [2:0] outCnt_q;
  logic [6:0] outShift_q;
  logic [7:0] loadByte;
  assign statusByte = '{rsvd: 6'h00, write_enable_latch: writeEnableLatch_q,
                        busy: busyFlag_q | startPend_q};
  assign loadByte = (state_q == ST_RDATA) ? arrRdata : statusByte;

  always_ff @(posedge clk) begin
    if (sys_rst || !csLow) begin
      serialOutLine_q <= 1'b0;
      serialOutEnN_q <= 1'b1;
      outCnt_q <= 3'h0;
      outShift_q <= 7'h00;
    end else if (sckFall && (state_q == ST_RDATA || state_q == ST_STAT)) begin
      serialOutEnN_q <= 1'b0;
      outCnt_q <= outCnt_q + 3'h1;
      if (outCnt_q == 3'h0) begin
        serialOutLine_q <= loadByte[7]; // RULE_01 RULE_24
        outShift_q <= loadByte[6:0];
      end else begin
        serialOutLine_q <= outShift_q[6];
        outShift_q <= {outShift_q[5:0], 1'b0};
      end
    end
  end

endmodule : sere_core

// ---- bench/sere_core_checker.sv ----
// Checks on the link pins and device flags of the command block.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/1ns
module sere_core_checker #(
  parameter int BusyCycles = 100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic deviceSelectN,
  input wire logic shiftClock,
  input wire logic serialOutLine_q,
  input wire logic serialOutEnN_q,
  // Flags
  input wire logic busyFlag_q,
  input wire logic writeEnableLatch_q
);
  int busyLen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Busy length counted here, the flag alone cannot show a short cycle
  always_ff @(posedge clk) begin
    busyLen_q <= (sys_rst || !busyFlag_q) ? 0 : busyLen_q + 1;
  end
  property p_enIdle;
    deviceSelectN [*6] |-> serialOutEnN_q;
  endproperty
  property p_busyStart;
    $rose(busyFlag_q) |-> deviceSelectN && $past(deviceSelectN, 2);
  endproperty
  property p_welRise;
    $rose(writeEnableLatch_q) |-> deviceSelectN && $past(deviceSelectN, 2);
  endproperty
  property p_busyNeedWel;
    $rose(busyFlag_q) |-> writeEnableLatch_q;
  endproperty
  property p_welClr;
    $fell(busyFlag_q) |-> !writeEnableLatch_q;
  endproperty
  property p_busyLen;
    $fell(busyFlag_q) |-> busyLen_q >= BusyCycles - 1
      && busyLen_q <= BusyCycles + 1;
  endproperty
  property p_welHold;
    busyFlag_q && $past(busyFlag_q) |-> $stable(writeEnableLatch_q);
  endproperty
  property p_outEdge;
    !serialOutEnN_q && !$past(serialOutEnN_q) && $changed(serialOutLine_q)
      |-> !$past(shiftClock, 1) && !$past(shiftClock, 2);
  endproperty
  a_enIdle: assert property (p_enIdle)
    else $error("output driven while deselected");
  a_busyStart: assert property (p_busyStart)
    else $error("busy began while selected");
  a_welRise: assert property (p_welRise)
    else $error("latch set while selected");
  a_busyNeedWel: assert property (p_busyNeedWel)
    else $error("cycle began without latch");
  a_welClr: assert property (p_welClr)
    else $error("latch kept after cycle");
  a_busyLen: assert property (p_busyLen)
    else $error("busy length wrong");
  a_welHold: assert property (p_welHold)
    else $error("latch moved during cycle");
  a_outEdge: assert property (p_outEdge)
    else $error("output moved off a falling edge");
  c_busy: cover property ($rose(busyFlag_q));
  c_wel: cover property ($rose(writeEnableLatch_q));
  c_out: cover property ($fell(serialOutEnN_q));
endmodule : sere_core_checker

bind sere_core sere_core_checker #(.BusyCycles(BusyCycles)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .deviceSelectN(deviceSelectN),
  .shiftClock(shiftClock), .serialOutLine_q(serialOutLine_q),
  .serialOutEnN_q(serialOutEnN_q), .busyFlag_q(busyFlag_q),
  .writeEnableLatch_q(writeEnableLatch_q)
);

// ---- bench/sere_host_model.sv ----
// Host controller model: frames link transfers, MSB first, mode 0.
// Assumes clk is the bench clock; link half period is 4 clk (200 ns).
`timescale 1ns/1ns
module sere_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic deviceSelectN,
  output logic shiftClock,
  output logic serialInLine,
  input wire logic serialOutLine_q,
  // Received bytes
  output logic [7:0] rxByte,
  output logic rxStb
);
  logic [7:0] txQ[$];
  logic [7:0] rxSh;
  initial begin
    deviceSelectN = 1'b1;
    shiftClock = 1'b0;
    serialInLine = 1'b1;
    rxByte = 8'h00;
    rxStb = 1'b0;
  end
  // Bits past the queued bytes carry noise and are captured as read data
  task automatic frame(input int nBits);
    logic [7:0] b;
    int i;
    b = 8'h00;
    @(posedge clk);
    deviceSelectN <= 1'b0;
    for (i = 0; i < nBits; i++) begin
      if (i % 8 == 0)
        b = (i < 8 * txQ.size()) ? txQ[i / 8] : 8'($urandom);
      shiftClock <= 1'b0;
      serialInLine <= b[7 - i % 8];
      repeat (4) @(posedge clk);
      shiftClock <= 1'b1;
      rxSh = {rxSh[6:0], serialOutLine_q};
      if (i >= 8 * txQ.size() && i % 8 == 7) begin
        rxByte <= rxSh;
        rxStb <= 1'b1;
      end
      @(posedge clk);
      rxStb <= 1'b0;
      repeat (3) @(posedge clk);
    end
    shiftClock <= 1'b0;
    repeat (2) @(posedge clk);
    deviceSelectN <= 1'b1;
    serialInLine <= ~serialInLine;
    repeat (8) @(posedge clk);
    txQ.delete();
  endtask : frame
endmodule : sere_host_model

// ---- bench/sere_core_tb_top.sv ----
// Self-checking bench for the command block with a host model.
// Assumes the core, its package and the constants header are compiled.
`timescale 1ns/1ns
`include "sere_defs.svh"
module sere_core_tb_top;
  import sere_pkg::*;
  // Short self-timed cycle, still long enough to fetch status meanwhile
  localparam int BusyCyc = 400;
  logic clk, sys_rst;
  // Link and flag nets are driven by the instances' outputs
  wire logic deviceSelectN, shiftClock, serialInLine;
  wire logic serialOutLine_q, serialOutEnN_q, busyFlag_q, writeEnableLatch_q;
  wire logic [7:0] rxByte;
  wire logic rxStb;
  logic [7:0] b;
  // High while a refused command's frame runs: the line stays undriven
  logic ignRd;
  logic [7:0] expQ[$];
  logic [7:0] pg0[64];
  logic [7:0] dTop[4];
  sereStatus_t busySt;
  int errorCnt, nChecks, cycCnt, i;
  sere_core #(.BusyCycles(BusyCyc)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .deviceSelectN(deviceSelectN), .shiftClock(shiftClock),
    .serialInLine(serialInLine), .serialOutLine_q(serialOutLine_q),
    .serialOutEnN_q(serialOutEnN_q), .busyFlag_q(busyFlag_q),
    .writeEnableLatch_q(writeEnableLatch_q));
  sere_host_model host_u (.clk(clk), .deviceSelectN(deviceSelectN),
    .shiftClock(shiftClock), .serialInLine(serialInLine),
    .serialOutLine_q(serialOutLine_q), .rxByte(rxByte), .rxStb(rxStb));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    if (errorCnt == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic fail(input string msg);
    errorCnt++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) fail($sformatf("byte %h, wanted %h", got, exp));
  endtask : cmp_byte
  task automatic cmp_flag(input logic got, input logic exp, input string m);
    nChecks++;
    if (got !== exp) fail(m);
  endtask : cmp_flag
  task automatic hdr(input logic [7:0] op, input logic [14:0] a);
    host_u.txQ = {op, 8'({1'b0, a[14:8]}), a[7:0]};
  endtask : hdr
  task automatic unlock();
    host_u.txQ = {`SERE_OP_STORE_UNLOCK};
    host_u.frame(8);
  endtask : unlock
  task automatic wait_idle();
    int n;
    for (n = 0; n < 600 && busyFlag_q !== 1'b0; n++) @(posedge clk);
    cmp_flag(busyFlag_q, 1'b0, "busy stuck");
  endtask : wait_idle
  // Every byte seen on the link is matched to the oldest expectation
  always @(posedge clk) begin
    cycCnt++;
    if (rxStb === 1'b1) begin
      cmp_flag(serialOutEnN_q, ignRd, "output enable wrong");
      if (expQ.size() == 0) fail("byte with nothing expected");
      else cmp_byte(rxByte, expQ.pop_front());
    end
    if (cycCnt == 40000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  initial begin
    sys_rst = 1'b1;
    errorCnt = 0;
    nChecks = 0;
    cycCnt = 0;
    ignRd = 1'b0;
    void'($urandom(32'h926F));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    host_u.txQ = {`SERE_OP_STATUS_FETCH};
    expQ.push_back(8'h00);
    host_u.frame(16);
    host_u.txQ = {`SERE_OP_STORE_UNLOCK};
    // Whole opcode, then five stray bits: select rises off a byte boundary
    host_u.frame(13);
    cmp_flag(writeEnableLatch_q, 1'b0, "latch set by part");
    hdr(`SERE_OP_PROGRAM, 15'h0001);
    host_u.txQ.push_back(8'h5A);
    host_u.frame(32);
    cmp_flag(busyFlag_q, 1'b0, "program without latch");
    unlock();
    cmp_flag(writeEnableLatch_q, 1'b1, "latch not set");
    hdr(`SERE_OP_PAGE_ERASE, 15'h0025);
    host_u.frame(24);
    cmp_flag(busyFlag_q, 1'b1, "erase not started");
    wait_idle();
    cmp_flag(writeEnableLatch_q, 1'b0, "latch kept");
    foreach (pg0[k]) pg0[k] = `SERE_ERASED_BYTE;
    unlock();
    hdr(`SERE_OP_PROGRAM, 15'h0001);
    for (i = 1; i < 3; i++) begin
      pg0[i] = 8'($urandom);
      host_u.txQ.push_back(pg0[i]);
    end
    host_u.frame(40);
    busySt = '{rsvd: 6'h00, write_enable_latch: 1'b1, busy: 1'b1};
    host_u.txQ = {`SERE_OP_STATUS_FETCH};
    expQ.push_back(busySt);
    host_u.frame(16);
    unlock();
    // A read decoded while still busy must stay silent
    hdr(`SERE_OP_READ, 15'h0001);
    expQ.push_back(8'h00);
    ignRd = 1'b1;
    host_u.frame(32);
    ignRd = 1'b0;
    wait_idle();
    cmp_flag(writeEnableLatch_q, 1'b0, "latch survived");
    hdr(`SERE_OP_FAST_READ, 15'h0000);
    host_u.txQ.push_back(8'($urandom));
    for (i = 0; i < 4; i++) expQ.push_back(pg0[i]);
    host_u.frame(64);
    unlock();
    hdr(`SERE_OP_PROGRAM, 15'h0000);
    for (i = 0; i < 66; i++) begin
      b = 8'($urandom);
      pg0[i % 64] = b;
      host_u.txQ.push_back(b);
    end
    host_u.frame(24 + 66 * 8);
    wait_idle();
    unlock();
    hdr(`SERE_OP_PROGRAM, 15'h7FFE);
    for (i = 0; i < 4; i++) begin
      dTop[i] = 8'($urandom);
      host_u.txQ.push_back(dTop[i]);
    end
    host_u.frame(56);
    wait_idle();
    hdr(`SERE_OP_READ, 15'h7FFE);
    expQ.push_back(dTop[0]);
    expQ.push_back(dTop[1]);
    for (i = 0; i < 64; i++) expQ.push_back(pg0[i]);
    host_u.frame(24 + 66 * 8);
    hdr(`SERE_OP_READ, 15'h7FC0);
    expQ.push_back(dTop[2]);
    expQ.push_back(dTop[3]);
    host_u.frame(40);
    hdr(`SERE_OP_FAST_READ, 15'h7FFF);
    host_u.txQ.push_back(8'($urandom));
    expQ.push_back(dTop[1]);
    expQ.push_back(pg0[0]);
    host_u.frame(48);
    cmp_flag(expQ.size() == 0, 1'b1, "bytes missing");
    report_and_stop();
  end
endmodule : sere_core_tb_top
